// *** design/cwc_defs.svh ***
/*
 * Constants of the clock warm-up counter: register offsets, field
 * positions, reset values, mode encodings and timing figures.
 * Assumes inclusion by bare name from the package and the checker.
 */
`ifndef CWC_DEFS_SVH
`define CWC_DEFS_SVH

// register offsets on the plain register port
`define CWC_ADDR_W 4
`define CWC_OFS_LOWER_CTRL 4'h0
`define CWC_OFS_UPPER_CTRL 4'h1
`define CWC_OFS_CMP_LOW 4'h2
`define CWC_OFS_CMP_HIGH 4'h3
`define CWC_OFS_SYS_CTRL 4'h4
`define CWC_OFS_COUNT_LOW 4'h5
`define CWC_OFS_COUNT_HIGH 4'h6
`define CWC_OFS_IRQ_STATUS 4'h7
`define CWC_OFS_IRQ_MASK 4'h8

// upper_timer_ctrl fields
`define CWC_UP_MODE_LSB 0
`define CWC_UP_MODE_MSB 2
`define CWC_UP_RUN_BIT 3
`define CWC_UP_OUT_BIT 7
`define CWC_MODE_WARMUP 3'h5

// lower_timer_ctrl fields
`define CWC_LO_CASC_LSB 0
`define CWC_LO_CASC_MSB 1
`define CWC_LO_SRC_LSB 4
`define CWC_LO_SRC_MSB 6
`define CWC_LO_OUT_BIT 7
`define CWC_CASC_16BIT 2'h3
`define CWC_SRC_SLOW 3'h4
`define CWC_SRC_FAST 3'h6

// system_ctrl_two fields
`define CWC_SYS_CLK_SEL_BIT 5
`define CWC_SYS_SLOW_EN_BIT 6
`define CWC_SYS_FAST_EN_BIT 7

// reset values
`define CWC_RST_LOWER_CTRL 8'h00
`define CWC_RST_UPPER_CTRL 8'h00
`define CWC_RST_CMP 8'h00
`define CWC_RST_SYS_CTRL 8'h80
`define CWC_RST_IRQ 8'h00
`define CWC_RST_COUNT 16'h0000

// interrupt status / mask bit
`define CWC_IRQ_MATCH_BIT 0

// warm-up figures: source ticks and expected times
`define CWC_CMP_MIN 16'h0100
`define CWC_CMP_MAX 16'hff00
`define CWC_SLOW_MIN_US 7810
`define CWC_SLOW_MAX_US 1990000
`define CWC_FAST_MIN_NS 16000
`define CWC_FAST_MAX_NS 4080000

// system clock
`define CWC_CLOCK_PERIOD_NS 25

`endif

// *** design/cwc_pkg.sv ***
/*
 * Types of the clock warm-up counter.
 * Assumes cwc_defs.svh is on the include path.
 */
package cwc_pkg;
   `include "cwc_defs.svh"

   // run state of the cascaded pair
   typedef enum logic [0:0] {
      CWC_STOPPED = 1'b0,
      CWC_COUNTING = 1'b1
   } cwc_run_type;

   // counting source decoded from lower_timer_ctrl
   typedef enum logic [1:0] {
      CWC_SRC_NONE_SEL = 2'b00,
      CWC_SRC_SLOW_SEL = 2'b01,
      CWC_SRC_FAST_SEL = 2'b10
   } cwc_src_type;
endpackage

// *** design/cwc_warmup_counter.sv ***
/*
 * Warm-up counter of two cascaded 8-bit timers forming a 16-bit
 * up-counter, with its control, compare, system clock control and
 * interrupt registers behind a plain register port.
 * Assumes slow_clock and fast_clock arrive as pins from outside this
 * clock domain, each much slower than clock, and a register master
 * that never issues read and write strobes together.
 */
// Chosen here: the plain strobed port and the register offsets.
// Notes on behaviour
// - run bit starts count; match clears, interrupts
// - slow mode: 0100H about 7.81 ms
// - fast mode: 0100H 16 us, FF00H 4.08 ms
// - upper control 05H: warm-up mode, stopped
// - lower control 43H: slow source, cascade
// - upper control bit 3 runs the pair
// - system control bit 5 selects clock
// - system control bits 7, 6 enable oscillators
// - compare uses only upper eight bits
`timescale 1ns/1ps

module cwc_warmup_counter #(
   parameter int DATA_W = 8, // register data width
   parameter int SYNC_STAGES = 3 // pin synchroniser depth
) (
   input wire logic clock, // 40 MHz system clock
   input wire logic rstn, // asynchronous reset, active low
   input wire logic [`CWC_ADDR_W-1:0] reg_addr, // register address
   input wire logic [DATA_W-1:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [DATA_W-1:0] reg_rdata, // read data, cycle after rd
   input wire logic slow_clock, // low-frequency clock pin
   input wire logic fast_clock, // high-frequency clock pin
   output logic pair_match_irq, // one-cycle match pulse
   output logic irq, // level interrupt, masked status
   output logic sys_clk_slow_sel, // system clock from slow osc
   output logic fast_osc_en, // fast oscillator enable
   output logic slow_osc_en, // slow oscillator enable
   output logic upper_out_flop, // upper timer output flop
   output logic lower_out_flop, // lower timer output flop
   output logic pair_running // pair is counting
);
   import cwc_pkg::*;

   // the logic below is written for byte registers and a 3-flop sync
   generate
      if (DATA_W != 8) begin : g_bad_data_w
         $error("cwc_warmup_counter: DATA_W must be 8");
      end
      if (SYNC_STAGES != 3) begin : g_bad_sync
         $error("cwc_warmup_counter: SYNC_STAGES must be 3");
      end
   endgenerate

   // expected warm-up lengths in system clock cycles, for reference
   localparam longint SLOW_MIN_CYC =
      (longint'(`CWC_SLOW_MIN_US) * 1000) / `CWC_CLOCK_PERIOD_NS;
   localparam longint FAST_MIN_CYC =
      (longint'(`CWC_FAST_MIN_NS) + `CWC_CLOCK_PERIOD_NS - 1)
      / `CWC_CLOCK_PERIOD_NS;
   localparam longint FAST_MAX_CYC =
      longint'(`CWC_FAST_MAX_NS) / `CWC_CLOCK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [DATA_W-1:0] upper_timer_ctrl;
   logic [DATA_W-1:0] lower_timer_ctrl;
   logic [DATA_W-1:0] compare_low_byte;
   logic [DATA_W-1:0] compare_high_byte;
   logic [DATA_W-1:0] system_ctrl_two;
   logic [DATA_W-1:0] irq_status;
   logic [DATA_W-1:0] irq_mask;
   logic [15:0] count;
   cwc_run_type run_state;
   cwc_run_type next_run_state;

   // decoded write strobes
   function automatic logic wr_hit(input logic [`CWC_ADDR_W-1:0] a,
                                   input logic [`CWC_ADDR_W-1:0] ofs);
      wr_hit = (a == ofs);
   endfunction

   logic wr_upper;
   logic wr_lower;
   logic wr_cmp_low;
   logic wr_cmp_high;
   logic wr_sys;
   logic wr_status;
   logic wr_mask;

   // strobe decode
   always_comb begin
      wr_upper = reg_wr && wr_hit(reg_addr, `CWC_OFS_UPPER_CTRL);
      wr_lower = reg_wr && wr_hit(reg_addr, `CWC_OFS_LOWER_CTRL);
      wr_cmp_low = reg_wr && wr_hit(reg_addr, `CWC_OFS_CMP_LOW);
      wr_cmp_high = reg_wr && wr_hit(reg_addr, `CWC_OFS_CMP_HIGH);
      wr_sys = reg_wr && wr_hit(reg_addr, `CWC_OFS_SYS_CTRL);
      wr_status = reg_wr && wr_hit(reg_addr, `CWC_OFS_IRQ_STATUS);
      wr_mask = reg_wr && wr_hit(reg_addr, `CWC_OFS_IRQ_MASK);
   end

   // upper control: mode, run bit and out flop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         upper_timer_ctrl <= `CWC_RST_UPPER_CTRL;
      end else if (wr_upper) begin
         upper_timer_ctrl <= reg_wdata;
      end
   end

   // lower control: source select, cascade and out flop
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lower_timer_ctrl <= `CWC_RST_LOWER_CTRL;
      end else if (wr_lower) begin
         lower_timer_ctrl <= reg_wdata;
      end
   end

   // compare bytes; the low byte is stored but never compared
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         compare_low_byte <= `CWC_RST_CMP;
         compare_high_byte <= `CWC_RST_CMP;
      end else begin
         if (wr_cmp_low) begin
            compare_low_byte <= reg_wdata;
         end
         if (wr_cmp_high) begin
            compare_high_byte <= reg_wdata;
         end
      end
   end

   // system control: clock select and oscillator enables
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         system_ctrl_two <= `CWC_RST_SYS_CTRL;
      end else if (wr_sys) begin
         system_ctrl_two <= reg_wdata;
      end
   end

   // system clock and oscillator controls straight from the register
   always_comb begin
      sys_clk_slow_sel = system_ctrl_two[`CWC_SYS_CLK_SEL_BIT];
      fast_osc_en = system_ctrl_two[`CWC_SYS_FAST_EN_BIT];
      slow_osc_en = system_ctrl_two[`CWC_SYS_SLOW_EN_BIT];
      upper_out_flop = upper_timer_ctrl[`CWC_UP_OUT_BIT];
      lower_out_flop = lower_timer_ctrl[`CWC_LO_OUT_BIT];
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers for the two source clocks
   logic [1:0] pin_in;
   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic [1:0] sync_c;
   logic [1:0] pin_level;
   logic [1:0] pin_rise;

   assign pin_in = {fast_clock, slow_clock};

   // stage a is read only by stage b
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
               sync_c[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= pin_in[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
            end
         end

         // a change counts once stages b and c agree
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               pin_level[gi] <= 1'b0;
            end else if (sync_b[gi] == sync_c[gi]) begin
               pin_level[gi] <= sync_c[gi];
            end
         end

         assign pin_rise[gi] = (sync_b[gi] == sync_c[gi]) &&
                               sync_c[gi] && !pin_level[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // source decode and counting
   cwc_src_type src_sel;
   logic src_tick;
   logic warmup_mode;
   logic match;

   // source select; unlisted codes give no ticks at all
   always_comb begin
      case (lower_timer_ctrl[`CWC_LO_SRC_MSB:`CWC_LO_SRC_LSB])
         `CWC_SRC_SLOW: src_sel = CWC_SRC_SLOW_SEL;
         `CWC_SRC_FAST: src_sel = CWC_SRC_FAST_SEL;
         default: src_sel = CWC_SRC_NONE_SEL;
      endcase
   end

   // one tick per rising edge of the chosen source
   always_comb begin
      case (src_sel)
         CWC_SRC_SLOW_SEL: src_tick = pin_rise[0];
         CWC_SRC_FAST_SEL: src_tick = pin_rise[1];
         default: src_tick = 1'b0;
      endcase
   end

   // pair only counts as warm-up counter when both halves agree
   assign warmup_mode =
      (upper_timer_ctrl[`CWC_UP_MODE_MSB:`CWC_UP_MODE_LSB] ==
       `CWC_MODE_WARMUP) &&
      (lower_timer_ctrl[`CWC_LO_CASC_MSB:`CWC_LO_CASC_LSB] ==
       `CWC_CASC_16BIT);

   // run state follows the run bit and warm-up mode; bit 3 starts only in warm-up mode, and either one stops
   always_comb begin
      case (run_state)
         CWC_STOPPED: begin
            if (upper_timer_ctrl[`CWC_UP_RUN_BIT] && warmup_mode) begin
               next_run_state = CWC_COUNTING;
            end else begin
               next_run_state = CWC_STOPPED;
            end
         end
         CWC_COUNTING: begin
            if (!upper_timer_ctrl[`CWC_UP_RUN_BIT] || !warmup_mode) begin
               next_run_state = CWC_STOPPED;
            end else begin
               next_run_state = CWC_COUNTING;
            end
         end
         default: next_run_state = CWC_STOPPED;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         run_state <= CWC_STOPPED;
      end else begin
         run_state <= next_run_state;
      end
   end

   assign pair_running = (run_state == CWC_COUNTING);

   // low byte ignored: match fires on reaching high byte x 256 ticks,
   // so a compare high byte of zero never matches
   assign match = pair_running && (compare_high_byte != 8'h00) &&
                  (count[15:8] == compare_high_byte);

   // up-counter; clears on match, holds while stopped
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         count <= `CWC_RST_COUNT;
      end else if (match) begin
         count <= `CWC_RST_COUNT;
      end else if (pair_running && src_tick) begin
         count <= count + 16'h0001;
      end
   end // no change while stopped

   ////////////////////////////////////////////////////////////////////
   // interrupt request, sticky status and mask

   // match is a single cycle because the count clears on it
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pair_match_irq <= 1'b0;
      end else begin
         pair_match_irq <= match;
      end
   end

   // write one to clear; a match in the same cycle wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_status <= `CWC_RST_IRQ;
      end else begin
         if (wr_status) begin
            irq_status <= irq_status & ~reg_wdata;
         end
         if (match) begin
            irq_status[`CWC_IRQ_MATCH_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         irq_mask <= `CWC_RST_IRQ;
      end else if (wr_mask) begin
         irq_mask <= reg_wdata;
      end
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////
   // read path: data stand in the cycle after the strobe only
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `CWC_OFS_LOWER_CTRL: next_rdata = lower_timer_ctrl;
            `CWC_OFS_UPPER_CTRL: next_rdata = upper_timer_ctrl;
            `CWC_OFS_CMP_LOW: next_rdata = compare_low_byte;
            `CWC_OFS_CMP_HIGH: next_rdata = compare_high_byte;
            `CWC_OFS_SYS_CTRL: next_rdata = system_ctrl_two;
            `CWC_OFS_COUNT_LOW: next_rdata = count[7:0];
            `CWC_OFS_COUNT_HIGH: next_rdata = count[15:8];
            `CWC_OFS_IRQ_STATUS: next_rdata = irq_status;
            `CWC_OFS_IRQ_MASK: next_rdata = irq_mask;
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule

// *** verif/cwc_warmup_asserts.sv ***
/*
 * Port-level checker of the clock warm-up counter.
 * Assumes it is bound to cwc_warmup_counter and that cwc_defs.svh
 * is on the include path.
 */
`timescale 1ns/1ps
`include "cwc_defs.svh"

module cwc_warmup_asserts #(
   parameter int DATA_W = 8 // register data width
) (
   input wire logic clock, // system clock
   input wire logic rstn, // reset, active low
   input wire logic [`CWC_ADDR_W-1:0] reg_addr, // address
   input wire logic [DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [DATA_W-1:0] reg_rdata, // read data
   input wire logic pair_match_irq, // match pulse
   input wire logic irq, // level interrupt
   input wire logic sys_clk_slow_sel, // clock select
   input wire logic fast_osc_en, // fast osc enable
   input wire logic slow_osc_en, // slow osc enable
   input wire logic upper_out_flop, // upper flop
   input wire logic lower_out_flop, // lower flop
   input wire logic pair_running // counting
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////
   // write steps; run state lags its register by one cycle
   sequence wr_upper;
      reg_wr && reg_addr == `CWC_OFS_UPPER_CTRL;
   endsequence
   sequence wr_upper_stop;
      reg_wr && reg_addr == `CWC_OFS_UPPER_CTRL && !reg_wdata[3];
   endsequence
   sequence wr_sys;
      reg_wr && reg_addr == `CWC_OFS_SYS_CTRL;
   endsequence

   ////////////////////////////////////////////////////////////////////
   chk_match_one_cycle: assert property (
      pair_match_irq |=> !pair_match_irq)
      else $error("match pulse longer than one cycle");
   chk_match_when_run: assert property (
      $rose(pair_match_irq) |-> $past(pair_running))
      else $error("match pulse while pair stopped");
   chk_stop_halts: assert property (
      wr_upper_stop |=> ##1 !pair_running)
      else $error("pair still running after stop");
   chk_upper_flop: assert property (
      wr_upper |=> upper_out_flop == $past(reg_wdata[7]))
      else $error("upper flop not loaded");
   chk_lower_flop: assert property (
      reg_wr && reg_addr == `CWC_OFS_LOWER_CTRL
      |=> lower_out_flop == $past(reg_wdata[7]))
      else $error("lower flop not loaded");
   chk_clock_select: assert property (
      wr_sys |=> sys_clk_slow_sel == $past(reg_wdata[5]))
      else $error("clock select not loaded");
   chk_osc_enables: assert property (
      wr_sys |=> fast_osc_en == $past(reg_wdata[7])
      && slow_osc_en == $past(reg_wdata[6]))
      else $error("oscillator enables not loaded");
   chk_clear_drops: assert property (
      reg_wr && reg_addr == `CWC_OFS_IRQ_STATUS && reg_wdata[0]
      |=> !irq || pair_match_irq)
      else $error("interrupt stays after clear");
   chk_mask_drops: assert property (
      reg_wr && reg_addr == `CWC_OFS_IRQ_MASK && !reg_wdata[0] |=> !irq)
      else $error("interrupt stays after mask");
   chk_read_idle: assert property (
      !reg_rd |=> reg_rdata == '0)
      else $error("read data outside read cycle");
endmodule

bind cwc_warmup_counter cwc_warmup_asserts #(.DATA_W(DATA_W)) u_chk (
   .clock(clock), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pair_match_irq(pair_match_irq), .irq(irq),
   .sys_clk_slow_sel(sys_clk_slow_sel), .fast_osc_en(fast_osc_en),
   .slow_osc_en(slow_osc_en), .upper_out_flop(upper_out_flop),
   .lower_out_flop(lower_out_flop), .pair_running(pair_running));

// *** verif/cwc_warmup_counter_test.sv ***
/*
 * Self-checking bench of the clock warm-up counter: register tasks,
 * source pulses on both pins, slow and fast warm-up sequences.
 * Assumes the package and cwc_defs.svh compile before this file.
 */
`timescale 1ns/1ps

module cwc_warmup_counter_test;
   import cwc_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] pin = 2'h0;
   logic pair_match_irq, irq, sys_clk_slow_sel, fast_osc_en;
   logic slow_osc_en, upper_out_flop, lower_out_flop, pair_running;
   int fails = 0;
   int n_compared = 0;
   int n_match = 0;
   logic [7:0] got;
   logic [7:0] rst_addr [9] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6,
                                8'h7, 8'h8};
   logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
                               8'h00, 8'h00, 8'h00};

   cwc_warmup_counter dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .slow_clock(pin[0]), .fast_clock(pin[1]),
      .pair_match_irq(pair_match_irq), .irq(irq),
      .sys_clk_slow_sel(sys_clk_slow_sel), .fast_osc_en(fast_osc_en),
      .slow_osc_en(slow_osc_en), .upper_out_flop(upper_out_flop),
      .lower_out_flop(lower_out_flop), .pair_running(pair_running));

   // 40 MHz clock
   always #12.5 clock = ~clock;

   // match pulses are counted, so a match inside a pulse is not missed
   always @(posedge clock) begin
      if (pair_match_irq === 1'b1) n_match <= n_match + 1;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // each level lasts four clocks, above the synchroniser's need
   task automatic pulse(input int sel, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (4) @(posedge clock);
         pin[sel] <= ~pin[sel];
      end
      repeat (6) @(posedge clock);
      #1;
   endtask

   task automatic wait_match(input int target);
      for (int i = 0; i < 20 && n_match != target; i++) @(posedge clock);
      chk8(8'(n_match), 8'(target));
      if (n_match != target) summarize();
   endtask

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      #1 chk1(fast_osc_en, 1'b1);
      chk1(pair_running, 1'b0);
      // reset values, then an unmapped place
      foreach (rst_addr[i]) begin
         rd(rst_addr[i][3:0], got);
         chk8(got, rst_val[i]);
      end
      wr(4'hf, 8'hff);
      rd(4'hf, got);
      chk8(got, 8'h00);
      // out flops follow bit 7; run bit alone outside warm-up mode
      wr(4'h1, 8'h88);
      chk1(upper_out_flop, 1'b1);
      wr(4'h0, 8'h80);
      chk1(lower_out_flop, 1'b1);
      @(posedge clock);
      #1 chk1(pair_running, 1'b0);
      // slow warm-up setup
      wr(4'h4, 8'hc0);
      chk1(slow_osc_en, 1'b1);
      wr(4'h0, 8'h43);
      chk1(lower_out_flop, 1'b0);
      wr(4'h1, 8'h05);
      chk1(upper_out_flop, 1'b0);
      wr(4'h2, 8'h80);
      wr(4'h3, 8'h01);
      wr(4'h8, 8'h01);
      chk1(pair_running, 1'b0);
      wr(4'h1, 8'h0d);
      @(posedge clock);
      #1 chk1(pair_running, 1'b1);
      pulse(0, 255);
      pulse(1, 10);
      rd(4'h5, got);
      chk8(got, 8'hff);
      rd(4'h6, got);
      chk8(got, 8'h00);
      chk8(8'(n_match), 8'h00);
      // stopped count holds
      wr(4'h1, 8'h05);
      pulse(0, 3);
      rd(4'h5, got);
      chk8(got, 8'hff);
      wr(4'h1, 8'h0d);
      pulse(0, 1);
      wait_match(1);
      chk1(irq, 1'b1);
      rd(4'h5, got);
      chk8(got, 8'h00);
      rd(4'h7, got);
      chk8(got, 8'h01);
      // handler: stop, select slow, fast off
      wr(4'h1, 8'h05);
      wr(4'h4, 8'he0);
      chk1(sys_clk_slow_sel, 1'b1);
      wr(4'h4, 8'h60);
      chk1(fast_osc_en, 1'b0);
      wr(4'h7, 8'h01);
      chk1(irq, 1'b0);
      // fast warm-up with the interrupt masked
      wr(4'h4, 8'he0);
      wr(4'h0, 8'h63);
      wr(4'h8, 8'h00);
      wr(4'h1, 8'h0d);
      pulse(1, 256);
      wait_match(2);
      chk1(irq, 1'b0);
      wr(4'h8, 8'h01);
      chk1(irq, 1'b1);
      wr(4'h7, 8'h01);
      chk1(irq, 1'b0);
      // handler: stop, select fast, slow off
      wr(4'h1, 8'h05);
      wr(4'h4, 8'hc0);
      chk1(sys_clk_slow_sel, 1'b0);
      chk1(slow_osc_en, 1'b1);
      wr(4'h4, 8'h80);
      chk1(slow_osc_en, 1'b0);
      chk1(fast_osc_en, 1'b1);
      summarize();
   end
endmodule
